// File: include/ohp_map.svh
/*
  Constants of the display driver host port: strap codes, host register
  offsets, reset values, field positions and pin timing counts.
  Assumes a 10 MHz system clock on both ends.
*/
`ifndef OHP_MAP_SVH
`define OHP_MAP_SVH

// ----------------------------------------------------------------------
// Strap codes on port_sel_bit2..0
// ----------------------------------------------------------------------
`define OHP_MODE_6800 3'h4
`define OHP_MODE_8080 3'h6
`define OHP_MODE_SPI4 3'h0
`define OHP_MODE_SPI3 3'h1
`define OHP_MODE_I2C 3'h2

// ----------------------------------------------------------------------
// Host register map and fields
// ----------------------------------------------------------------------
`define OHP_REG_CTRL 2'h0
`define OHP_REG_TX 2'h1
`define OHP_REG_RXCMD 2'h2
`define OHP_REG_STATUS 2'h3
`define OHP_CTRL_RESET 4'h8
`define OHP_CTRL_INIT_BIT 3
`define OHP_DC_BIT 8
`define OHP_I2C_CO_BIT 7
`define OHP_I2C_DC_BIT 6
`define OHP_CMD_INIT 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OHP_CLK_MHZ 10
`define OHP_PAR_PULSE_NS 200
`define OHP_SER_HALF_NS 200
`define OHP_I2C_HALF_NS 1300
`define OHP_NS2CYC(ns) (((ns) * `OHP_CLK_MHZ + 999) / 1000)
`define OHP_PAR_PULSE_CYC 8'(`OHP_NS2CYC(`OHP_PAR_PULSE_NS))
`define OHP_SER_HALF_CYC 8'(`OHP_NS2CYC(`OHP_SER_HALF_NS))
`define OHP_I2C_HALF_CYC 8'(`OHP_NS2CYC(`OHP_I2C_HALF_NS))

`endif

// File: include/ohp_pkg.sv
/*
  Types shared by both ends of the display driver host port.
  Assumes ohp_map.svh is on the include path.
*/
`include "ohp_map.svh"

package ohp_pkg;

  // --------------------------------------------------------------------
  // Interface modes and state machines
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    OHP_M6800 = `OHP_MODE_6800,
    OHP_M8080 = `OHP_MODE_8080,
    OHP_MSPI4 = `OHP_MODE_SPI4,
    OHP_MSPI3 = `OHP_MODE_SPI3,
    OHP_MI2C = `OHP_MODE_I2C
  } ohp_mode_t;

  typedef enum logic [3:0] {
    OHP_I_IDLE = 4'b0001,
    OHP_I_RECV = 4'b0010,
    OHP_I_ACK = 4'b0100,
    OHP_I_SKIP = 4'b1000
  } ohp_i2c_st_t;

  typedef enum logic [6:0] {
    OHP_H_IDLE = 7'b0000001,
    OHP_H_PSET = 7'b0000010,
    OHP_H_PACT = 7'b0000100,
    OHP_H_PREL = 7'b0001000,
    OHP_H_SLO = 7'b0010000,
    OHP_H_SHI = 7'b0100000,
    OHP_H_STOP = 7'b1000000
  } ohp_host_st_t;

endpackage

// File: include/ohp_link_if.sv
/*
  Pin-level link between the display driver and its host.
  Data lines are resolved here from both enables with a pull-up,
  so open-drain serial lines read high when nobody drives them.
*/
`timescale 1ns/1ps

interface ohp_link_if;
  logic cs_n;
  logic data_command_sel;
  logic wr_pin;
  logic rd_pin;
  logic init_pin_n;
  logic [7:0] host_d_o;
  logic [7:0] host_d_oe;
  logic [7:0] dev_d_o;
  logic [7:0] dev_d_oe;
  logic busy;
  wire [7:0] d;

  // Device wins a clash; undriven lines float high
  assign d = (dev_d_oe & dev_d_o) | (~dev_d_oe & host_d_oe & host_d_o) |
    (~dev_d_oe & ~host_d_oe);

  modport dev (
    input cs_n, data_command_sel, wr_pin, rd_pin, init_pin_n, d,
    output dev_d_o, dev_d_oe, busy
  );
  modport host (
    output cs_n, data_command_sel, wr_pin, rd_pin, init_pin_n,
    output host_d_o, host_d_oe,
    input d, busy
  );
endinterface

// File: rtl/ohp_dev.sv
/*
  Display driver end of the host port: strap decode, parallel and serial
  receivers, read drive, and a FIFO toward the display core.
  Assumes link pins are synchronous to clock; straps are static.
*/
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "ohp_map.svh"

// ----------------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------------
module ohp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("ohp_fifo: DEPTH must be a power of two, at least 2");
    end
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_reg != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (clear) begin
        wp_reg <= '0;
        rp_reg <= '0;
        cnt_reg <= '0;
      end else begin
        wp_reg <= wp_reg + AW'(push);
        rp_reg <= rp_reg + AW'(pop);
        cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (ce && push && !clear) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule

// ----------------------------------------------------------------------
// Driver end
// ----------------------------------------------------------------------
// Function
// - Transfers accepted only while chip select low
// - Chip select high releases all data lines
// - Init pin low returns settings to initial
// - Select high marks byte as display data
// - Select low routes byte to command registers
// - I2C: select pin is slave address lsb
// - 8080 write captured on write strobe rise
// - 6800 write pin is read/write direction
// - 8080 drives bus while read strobe low
// - 6800 read pin is high enable clock
// - Parallel bus eight bits, both directions
// - SPI: line0 clock, line1 data, rest released
// - I2C: line0 clock, line1 data, rest released
// - Interface type chosen by three strap pins
// - Strap codes per mode tied by board
module ohp_dev import ohp_pkg::*; #(
  parameter int FIFO_DEPTH = 4,
  parameter logic [5:0] I2C_ADDR_HI = 6'h1E
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  ohp_link_if.dev link,
  input wire logic port_sel_bit2,
  input wire logic port_sel_bit1,
  input wire logic port_sel_bit0,
  input wire logic [7:0] rd_byte,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_byte,
  output logic out_is_data,
  output logic [2:0] mode_reg,
  output logic [7:0] last_cmd_reg
);
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("ohp_dev: FIFO_DEPTH below 2");
    end
  end

  // --------------------------------------------------------------------
  // Strap capture and decode
  // --------------------------------------------------------------------
  logic strap_done_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      mode_reg <= `OHP_MODE_SPI4;
    end else if (ce && !strap_done_reg) begin
      strap_done_reg <= 1'b1;
      mode_reg <= {port_sel_bit2, port_sel_bit1, port_sel_bit0};
    end
  end
  wire is_6800 = (mode_reg == OHP_M6800);
  wire is_8080 = (mode_reg == OHP_M8080);
  wire is_spi3 = (mode_reg == OHP_MSPI3);
  wire is_spi = (mode_reg == OHP_MSPI4) | is_spi3;
  wire is_i2c = (mode_reg == OHP_MI2C);

  // --------------------------------------------------------------------
  // Pin history
  // --------------------------------------------------------------------
  logic prev_wr_reg;
  logic prev_rd_reg;
  logic prev_scl_reg;
  logic prev_sda_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_wr_reg <= 1'b1;
      prev_rd_reg <= 1'b1;
      prev_scl_reg <= 1'b1;
      prev_sda_reg <= 1'b1;
    end else if (ce) begin
      prev_wr_reg <= link.wr_pin;
      prev_rd_reg <= link.rd_pin;
      prev_scl_reg <= link.d[0];
      prev_sda_reg <= link.d[1];
    end
  end
  wire sel = ~link.cs_n & link.init_pin_n & strap_done_reg;
  wire wr_rise = sel & is_8080 & ~prev_wr_reg & link.wr_pin;
  wire e_fall = sel & is_6800 & prev_rd_reg & ~link.rd_pin &
    ~link.wr_pin;
  wire par_read = sel & ((is_8080 & ~link.rd_pin) |
    (is_6800 & link.rd_pin & link.wr_pin));
  wire scl_rise = ~prev_scl_reg & link.d[0];
  wire scl_fall = prev_scl_reg & ~link.d[0];
  wire i2c_start = sel & is_i2c & link.d[0] & prev_scl_reg &
    prev_sda_reg & ~link.d[1];
  wire i2c_stop = is_i2c & link.d[0] & prev_scl_reg & ~prev_sda_reg &
    link.d[1];

  // --------------------------------------------------------------------
  // Serial shifter
  // --------------------------------------------------------------------
  logic [8:0] sh_reg;
  logic [3:0] bit_cnt_reg;
  ohp_i2c_st_t ist_reg;
  ohp_i2c_st_t ist_next;
  logic expect_ctrl_reg;
  logic co_reg;
  logic i2c_dc_reg;
  logic addr_phase_reg;
  logic fifo_ready;
  wire [8:0] sh_next = {sh_reg[7:0], link.d[1]};
  wire [3:0] spi_last = is_spi3 ? 4'h8 : 4'h7;
  wire spi_done = sel & is_spi & scl_rise & (bit_cnt_reg == spi_last);
  wire spi_dc = is_spi3 ? sh_next[8] : link.data_command_sel;
  wire byte_end = (ist_reg == OHP_I_RECV) & scl_fall &
    (bit_cnt_reg == 4'h8);
  wire addr_hit = (sh_reg[7:1] == {I2C_ADDR_HI,
    link.data_command_sel}) & ~sh_reg[0];
  wire is_ctrl = ~addr_phase_reg & expect_ctrl_reg;
  wire is_data = ~addr_phase_reg & ~expect_ctrl_reg;
  wire i2c_push = byte_end & is_data & fifo_ready;
  wire i2c_ack = addr_phase_reg ? addr_hit : (is_ctrl | fifo_ready);
  wire i2c_drive = (ist_reg == OHP_I_ACK);

  always_comb begin
    ist_next = ist_reg;
    case (ist_reg)
      OHP_I_IDLE: ist_next = OHP_I_IDLE;
      OHP_I_RECV: begin
        if (byte_end) begin
          ist_next = i2c_ack ? OHP_I_ACK : OHP_I_SKIP;
        end
      end
      OHP_I_ACK: begin
        if (scl_fall) begin
          ist_next = OHP_I_RECV;
        end
      end
      OHP_I_SKIP: ist_next = OHP_I_SKIP;
      default: ist_next = OHP_I_IDLE;
    endcase
    if (i2c_start) begin
      ist_next = OHP_I_RECV;
    end else if (i2c_stop || !sel) begin
      ist_next = OHP_I_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ist_reg <= OHP_I_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 9'h000;
    end else if (ce) begin
      ist_reg <= ist_next;
      if (!sel || i2c_start || spi_done || (i2c_drive && scl_fall)) begin
        bit_cnt_reg <= 4'h0;
      end else if (scl_rise && (is_spi || ist_reg == OHP_I_RECV)) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        sh_reg <= sh_next;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_phase_reg <= 1'b1;
      expect_ctrl_reg <= 1'b1;
      co_reg <= 1'b0;
      i2c_dc_reg <= 1'b0;
    end else if (ce) begin
      if (i2c_start) begin
        addr_phase_reg <= 1'b1;
        expect_ctrl_reg <= 1'b1;
      end else if (byte_end && i2c_ack) begin
        addr_phase_reg <= 1'b0;
        if (is_ctrl) begin
          co_reg <= sh_reg[`OHP_I2C_CO_BIT];
          i2c_dc_reg <= sh_reg[`OHP_I2C_DC_BIT];
          expect_ctrl_reg <= 1'b0;
        end else if (is_data) begin
          expect_ctrl_reg <= co_reg;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Byte delivery; a full FIFO raises busy and the I2C byte is refused
  // --------------------------------------------------------------------
  wire par_push = wr_rise | e_fall;
  wire push = par_push | spi_done | i2c_push;
  wire push_dc = par_push ? link.data_command_sel :
    (spi_done ? spi_dc : i2c_dc_reg);
  wire [7:0] push_byte = par_push ? link.d :
    (spi_done ? sh_next[7:0] : sh_reg[7:0]);
  wire [8:0] fifo_out;

  ohp_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .clear(~link.init_pin_n),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({push_dc, push_byte}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );
  assign out_is_data = fifo_out[8];
  assign out_byte = fifo_out[7:0];

  // --------------------------------------------------------------------
  // Pin drive and command register
  // --------------------------------------------------------------------
  logic [7:0] d_o_reg;
  logic [7:0] d_oe_reg;
  logic busy_reg;
  wire [7:0] oe_next = ~sel ? 8'h00 : (par_read ? 8'hFF :
    (i2c_drive ? 8'h02 : 8'h00));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      d_o_reg <= 8'h00;
      d_oe_reg <= 8'h00;
      busy_reg <= 1'b0;
      last_cmd_reg <= `OHP_CMD_INIT;
    end else if (ce) begin
      d_oe_reg <= oe_next;
      d_o_reg <= par_read ? rd_byte : 8'h00;
      busy_reg <= ~fifo_ready;
      if (!link.init_pin_n) begin
        last_cmd_reg <= `OHP_CMD_INIT;
      end else if (push && fifo_ready && !push_dc) begin
        last_cmd_reg <= push_byte;
      end
    end
  end
  assign link.dev_d_o = d_o_reg;
  assign link.dev_d_oe = d_oe_reg;
  assign link.busy = busy_reg;
endmodule

// File: rtl/ohp_host.sv
/*
  Host end of the display driver port: software registers and a
  sequencer that plays writes in all five modes and parallel reads.
  Assumes the CTRL mode field matches the driver's straps.
*/
`timescale 1ns/1ps
`include "ohp_map.svh"

module ohp_host import ohp_pkg::*; #(
  parameter logic [5:0] I2C_ADDR_HI = 6'h1E
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  ohp_link_if.host link
);
  initial begin
    if (`OHP_PAR_PULSE_CYC < 8'd2) begin
      $error("ohp_host: strobe too short for the driver's read lag");
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [3:0] ctrl_reg;
  logic [7:0] rx_reg;
  ohp_host_st_t st_reg;
  ohp_host_st_t st_next;
  wire [2:0] mode = ctrl_reg[2:0];
  wire is_par = (mode == OHP_M8080) | (mode == OHP_M6800);
  wire is_6800 = (mode == OHP_M6800);
  wire is_i2c = (mode == OHP_MI2C);
  wire busy = (st_reg != OHP_H_IDLE) | link.busy;
  wire go_wr = reg_wr & (reg_addr == `OHP_REG_TX) & ~busy;
  wire go_rd = reg_wr & (reg_addr == `OHP_REG_RXCMD) & ~busy & is_par;
  wire [7:0] half = is_i2c ? `OHP_I2C_HALF_CYC : `OHP_SER_HALF_CYC;
  wire [7:0] wbyte = reg_wdata[7:0];
  wire wdc = reg_wdata[`OHP_DC_BIT];
  wire [7:0] ctrl_byte = {1'b0, wdc, 6'h00};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `OHP_CTRL_RESET;
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      if (reg_wr && reg_addr == `OHP_REG_CTRL) begin
        ctrl_reg <= reg_wdata[3:0];
      end
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `OHP_REG_CTRL: reg_rdata <= {12'h000, ctrl_reg};
          `OHP_REG_STATUS: reg_rdata <= {rx_reg, 7'h00, busy};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  logic [7:0] tmr_reg;
  logic [7:0] tmr_next;
  logic [26:0] bits_reg;
  logic [26:0] bits_next;
  logic [26:0] rel_reg;
  logic [26:0] rel_next;
  logic [4:0] left_reg;
  logic [4:0] left_next;
  logic rd_op_reg;
  logic rd_op_next;
  logic cs_n_reg;
  logic cs_n_next;
  logic dc_reg;
  logic dc_next;
  logic wr_reg;
  logic wr_next;
  logic rd_reg;
  logic rd_next;
  logic [7:0] do_reg;
  logic [7:0] do_next;
  logic [7:0] doe_reg;
  logic [7:0] doe_next;
  wire tdone = (tmr_reg == 8'h01);
  wire bit_now = bits_reg[26];
  wire rel_now = rel_reg[26];

  always_comb begin
    st_next = st_reg;
    tmr_next = tdone ? tmr_reg : tmr_reg - 8'h01;
    bits_next = bits_reg;
    rel_next = rel_reg;
    left_next = left_reg;
    rd_op_next = rd_op_reg;
    cs_n_next = cs_n_reg;
    dc_next = dc_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    do_next = do_reg;
    doe_next = doe_reg;
    case (st_reg)
      OHP_H_IDLE: begin
        cs_n_next = 1'b1;
        wr_next = 1'b1;
        rd_next = ~is_6800;
        doe_next = 8'h00;
        if (go_wr || go_rd) begin
          cs_n_next = 1'b0;
          dc_next = wdc;
          rd_op_next = go_rd;
          tmr_next = half;
          if (is_par) begin
            wr_next = is_6800 ? go_rd : 1'b1;
            do_next = wbyte;
            doe_next = go_rd ? 8'h00 : 8'hFF;
            tmr_next = 8'h01;
            st_next = OHP_H_PSET;
          end else if (is_i2c) begin
            dc_next = 1'b0;
            // Select pin is parked low in I2C, so the address lsb is 0
            bits_next = {I2C_ADDR_HI, 1'b0, 1'b0, 1'b1,
              ctrl_byte, 1'b1, wbyte, 1'b1};
            rel_next = {8'h00, 1'b1, 8'h00, 1'b1, 8'h00, 1'b1};
            left_next = 5'd27;
            do_next = 8'h00;
            doe_next = 8'h02;
            st_next = OHP_H_SHI;
          end else begin
            bits_next = (mode == OHP_MSPI3) ? {wdc, wbyte, 18'h00000} :
              {wbyte, 19'h00000};
            rel_next = 27'h0000000;
            left_next = (mode == OHP_MSPI3) ? 5'd9 : 5'd8;
            do_next = 8'h00;
            doe_next = 8'h03;
            st_next = OHP_H_SLO;
          end
        end
      end
      OHP_H_PSET: begin
        if (tdone) begin
          tmr_next = `OHP_PAR_PULSE_CYC;
          st_next = OHP_H_PACT;
          if (is_6800) begin
            rd_next = 1'b1;
          end else if (rd_op_reg) begin
            rd_next = 1'b0;
          end else begin
            wr_next = 1'b0;
          end
        end
      end
      OHP_H_PACT: begin
        if (tdone) begin
          tmr_next = `OHP_PAR_PULSE_CYC;
          st_next = OHP_H_PREL;
          wr_next = is_6800 ? wr_reg : 1'b1;
          rd_next = ~is_6800;
        end
      end
      OHP_H_PREL: begin
        if (tdone) begin
          doe_next = 8'h00;
          cs_n_next = 1'b1;
          st_next = OHP_H_IDLE;
        end
      end
      OHP_H_SLO: begin
        do_next = {6'h00, bit_now, 1'b0};
        doe_next = is_i2c ? {6'h00, ~bit_now & ~rel_now, 1'b1} : 8'h03;
        if (tdone) begin
          tmr_next = half;
          do_next[0] = 1'b1;
          doe_next[0] = ~is_i2c;
          bits_next = {bits_reg[25:0], 1'b0};
          rel_next = {rel_reg[25:0], 1'b0};
          left_next = left_reg - 5'd1;
          st_next = OHP_H_SHI;
        end
      end
      OHP_H_SHI: begin
        if (tdone) begin
          tmr_next = half;
          st_next = (left_reg != 5'd0) ? OHP_H_SLO :
            (is_i2c ? OHP_H_STOP : OHP_H_PREL);
          // Clock and data low first, so the stop edge has its setup
          if (left_reg == 5'd0 && is_i2c) begin
            do_next = 8'h00;
            doe_next = 8'h03;
          end
        end
      end
      OHP_H_STOP: begin
        // Bit 0 holds the phase: clock low, then clock released
        do_next = {7'h00, do_reg[0]};
        doe_next = {6'h00, 1'b1, ~do_reg[0]};
        if (tdone) begin
          do_next[0] = 1'b1;
          doe_next[0] = 1'b0;
          tmr_next = half;
          st_next = do_reg[0] ? OHP_H_PREL : OHP_H_STOP;
        end
      end
      default: st_next = OHP_H_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= OHP_H_IDLE;
      tmr_reg <= 8'h01;
      bits_reg <= 27'h0000000;
      rel_reg <= 27'h0000000;
      left_reg <= 5'd0;
      rd_op_reg <= 1'b0;
      rx_reg <= 8'h00;
    end else if (ce) begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      bits_reg <= bits_next;
      rel_reg <= rel_next;
      left_reg <= left_next;
      rd_op_reg <= rd_op_next;
      if (st_reg == OHP_H_PACT && tdone && rd_op_reg) begin
        rx_reg <= link.d;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_reg <= 1'b1;
      dc_reg <= 1'b0;
      wr_reg <= 1'b1;
      rd_reg <= 1'b1;
      do_reg <= 8'h00;
      doe_reg <= 8'h00;
    end else if (ce) begin
      cs_n_reg <= cs_n_next;
      dc_reg <= dc_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      do_reg <= do_next;
      doe_reg <= doe_next;
    end
  end
  assign link.cs_n = cs_n_reg;
  assign link.data_command_sel = dc_reg;
  assign link.wr_pin = wr_reg;
  assign link.rd_pin = rd_reg;
  assign link.init_pin_n = ctrl_reg[`OHP_CTRL_INIT_BIT];
  assign link.host_d_o = do_reg;
  assign link.host_d_oe = doe_reg;
endmodule

// File: verif/ohp_link_properties.sv
/* Pin rules of the driver end, watched on the link.
   Assumes the bench wires it to the link and to mode_reg. */
`timescale 1ns/1ps
`include "ohp_map.svh"
module ohp_link_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic wr_pin,
  input wire logic rd_pin,
  input wire logic init_pin_n,
  input wire logic [7:0] dev_d_oe,
  input wire logic busy,
  input wire logic [2:0] mode_reg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----------
  // Reads: drive lags the strobe by one sample
  // ----------
  sequence s_rd80;
    (mode_reg == `OHP_MODE_8080 && !cs_n && !rd_pin && init_pin_n) [*2];
  endsequence
  sequence s_rd68;
    (mode_reg == `OHP_MODE_6800 && !cs_n && rd_pin && wr_pin &&
      init_pin_n) [*2];
  endsequence
  property p_idle;
    cs_n [*2] |-> dev_d_oe == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("drive while idle");
  property p_init;
    !init_pin_n [*3] |-> dev_d_oe == 8'h00 && !busy;
  endproperty
  a_init: assert property (p_init) else $error("init ignored");
  property p_rd80;
    s_rd80 |-> dev_d_oe == 8'hFF;
  endproperty
  a_rd80: assert property (p_rd80) else $error("8080 read");
  property p_rd68;
    s_rd68 |-> dev_d_oe == 8'hFF;
  endproperty
  a_rd68: assert property (p_rd68) else $error("6800 read");
  property p_wr68;
    (mode_reg == `OHP_MODE_6800 && !wr_pin) [*2] |-> dev_d_oe == 8'h00;
  endproperty
  a_wr68: assert property (p_wr68) else $error("6800 write");
  property p_width;
    mode_reg[2] && dev_d_oe != 8'h00 |-> dev_d_oe == 8'hFF;
  endproperty
  a_width: assert property (p_width) else $error("part bus");
  property p_spi;
    mode_reg[2:1] == 2'h0 |-> dev_d_oe == 8'h00;
  endproperty
  a_spi: assert property (p_spi) else $error("spi drive");
  property p_i2c;
    mode_reg == `OHP_MODE_I2C |-> (dev_d_oe & 8'hFD) == 8'h00;
  endproperty
  a_i2c: assert property (p_i2c) else $error("i2c drive");
endmodule

// File: verif/tb_ohp_port_pins.sv
/* Bench: host end and driver end joined by the link.
   Assumes rtl, link interface and checker are compiled. */
`timescale 1ns/1ps
`include "ohp_map.svh"
module tb_ohp_port_pins;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, v;
  logic [2:0] strap = 3'h0;
  logic [7:0] rd_byte = 8'h00;
  logic out_ready = 1'b0;
  logic out_valid, out_is_data;
  logic [7:0] out_byte, last_cmd_reg;
  logic [2:0] mode_reg;
  logic [31:0] seed = 32'h10;
  logic [8:0] q[$];
  logic [7:0] cmd_m = 8'h00;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
  int miscompares = 0;
  int samples_checked = 0;
  always #50 clock = ~clock;
  ohp_link_if link ();
  ohp_host ohp_host_inst (.clock(clock), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link.host));
  ohp_dev ohp_dev_inst (.clock(clock), .rst_n(rst_n), .ce(ce),
    .link(link.dev), .port_sel_bit2(strap[2]), .port_sel_bit1(strap[1]),
    .port_sel_bit0(strap[0]), .rd_byte(rd_byte), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte), .out_is_data(out_is_data),
    .mode_reg(mode_reg), .last_cmd_reg(last_cmd_reg));
  ohp_link_properties ohp_link_properties_inst (.clock(clock),
    .rst_n(rst_n), .cs_n(link.cs_n), .wr_pin(link.wr_pin),
    .rd_pin(link.rd_pin), .init_pin_n(link.init_pin_n),
    .dev_d_oe(link.dev_d_oe), .busy(link.busy), .mode_reg(mode_reg));
  // ----------
  // Tasks
  // ----------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, want, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [1:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
    @(posedge clock);
  endtask
  // Random ready stalls the consumer; bounded wait for the byte
  task automatic pop(input logic [8:0] e);
    int n;
    logic [31:0] r;
    n = 0;
    do begin
      r = rnd();
      out_ready <= r[0];
      @(negedge clock);
      n++;
      if (!(out_valid === 1'b1 && out_ready === 1'b1)) @(posedge clock);
    end while (!(out_valid === 1'b1 && out_ready === 1'b1) && n < 3000);
    if (out_valid !== 1'b1 || out_ready !== 1'b1) miscompares++;
    check("byte", {7'h00, out_is_data, out_byte}, {7'h00, e});
    check("cmd", {8'h00, last_cmd_reg}, {8'h00, cmd_m});
    @(posedge clock);
  endtask
  task automatic send(input logic [8:0] e);
    int n;
    n = 0;
    // A TX write while busy is dropped, so poll STATUS first
    do begin
      rd(`OHP_REG_STATUS);
      n++;
    end while (v[0] !== 1'b0 && n < 200);
    if (v[0] !== 1'b0) miscompares++;
    wr(`OHP_REG_TX, {7'h00, e});
    q.push_back(e);
    if (!e[8]) cmd_m = e[7:0];
    pop(q.pop_front());
  endtask
  task print_verdict();
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
  // ----------
  // Sequence: every strap code, then full FIFO and init
  // ----------
  initial begin
    for (int m = 0; m < 5; m++) begin
      rst_n <= 1'b0;
      strap <= modes[m];
      cmd_m = `OHP_CMD_INIT;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      wr(`OHP_REG_CTRL, {13'h0001, modes[m]});
      repeat (3) send(9'(rnd()));
      send(9'h0A5);
      if (modes[m][2]) begin
        rd_byte <= 8'(rnd());
        wr(`OHP_REG_RXCMD, 16'h0000);
        repeat (10) @(posedge clock);
        rd(`OHP_REG_STATUS);
        check("read", {8'h00, v[15:8]}, {8'h00, rd_byte});
      end
    end
    rd(`OHP_REG_TX);
    check("tx read", v, 16'h0000);
    out_ready <= 1'b0;
    repeat (5) begin
      v = {7'h00, 9'(rnd())};
      wr(`OHP_REG_TX, v);
      if (q.size() < 4) begin
        q.push_back(v[8:0]);
        if (!v[8]) cmd_m = v[7:0];
      end
      repeat (8) @(posedge clock);
    end
    check("full", {15'h0000, link.busy}, 16'h0001);
    while (q.size() > 0) pop(q.pop_front());
    send(9'h03C);
    out_ready <= 1'b0;
    wr(`OHP_REG_CTRL, {13'h0000, 3'h6});
    wr(`OHP_REG_TX, 16'h015A);
    repeat (10) @(negedge clock);
    check("init", {7'h00, out_valid, last_cmd_reg}, 16'h0000);
    print_verdict();
  end
endmodule
